// ==== src/plrs_pkg.sv ====
// Constants and types for the program counter and return stack block.
// Assumes one clock domain shared with the instruction decoder.
`default_nettype none

package plrs_pkg;

  // ----------------------------------------------------------------
  // Widths and stack constants
  // ----------------------------------------------------------------
  localparam int          PC_W        = 15;
  localparam int          PCH_W       = 7;
  localparam int          BYTE_W      = 8;
  localparam int          CALL_OPD_W  = 11;
  localparam int          PTR_W       = 5;
  localparam int          STACK_DEPTH = 16;
  localparam int          IDX_W       = 4;
  localparam int          LATCH_SEG_LO = 3;
  localparam logic [4:0]  PTR_EMPTY   = 5'h1f;
  localparam logic [4:0]  PTR_LAST    = 5'h0f;
  localparam logic [4:0]  PTR_STEP    = 5'h01;
  localparam logic [14:0] PC_STEP     = 15'h0001;
  localparam logic [14:0] PC_RESET    = 15'h0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  REG_PC_LOW      = 8'h00;
  localparam logic [7:0]  REG_PC_LATCH    = 8'h04;
  localparam logic [7:0]  REG_STACK_PTR   = 8'h08;
  localparam logic [7:0]  REG_TOP_LOW     = 8'h0c;
  localparam logic [7:0]  REG_TOP_HIGH    = 8'h10;
  localparam logic [7:0]  REG_CTRL        = 8'h14;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h18;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h1c;
  localparam int          CTRL_FAULT_RST  = 0;
  localparam int          ST_OVF          = 0;
  localparam int          ST_UNF          = 1;
  localparam int          ST_W            = 2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // Core operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PLRS_OP_STEP,
    PLRS_OP_CALL,
    PLRS_OP_CALL_VIA_ACCUMULATOR,
    PLRS_OP_BRW,
    PLRS_OP_BRA,
    PLRS_OP_RETURN,
    PLRS_OP_RETLIT,
    PLRS_OP_RETINT,
    PLRS_OP_INTR
  } plrs_op_t;

endpackage

`default_nettype wire

// ==== src/plrs_stack_mem.sv ====
// Return stack storage: one write port, one combinational read port.
// Assumes writes and reads share the core clock.
`default_nettype none

module plrs_stack_mem
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15,
  parameter int AW    = 4
)
(
  input  wire logic             aclk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] entry_mem [DEPTH];

  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      entry_mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = entry_mem[rd_addr];

endmodule

`default_nettype wire

// ==== src/plrs_top.sv ====
// Program counter loading and 16-entry return stack with AXI4-Lite access.
// Assumes the decoder drives cmd_valid/cmd_op on the same clock.
//
// Function
// - Call loads low 11 bits from operand, bits 14..11 from latch bits 6..3.
// - Call via accumulator loads low byte from accumulator, upper from latch.
// - Accumulator jump loads counter plus one plus unsigned accumulator.
// - Literal jump loads counter plus one plus sign-extended operand bits 8..0.
// - Sixteen-entry, fifteen-bit return stack kept apart from memories.
// - Push on calls and interrupt; pop on the three return forms.
// - Push and pop leave the high latch untouched.
// - With fault reset disabled the stack wraps, overwriting oldest entries.
// - Overflow and underflow flags set regardless of fault reset enable.
// - Pointer selects an entry; top low/high registers read and write it.
// - Pointer is five bits wide to expose overflow and underflow.
// - Push increments pointer then writes; pop reads then decrements.
// - Reset clears the whole program counter.
// - Writing the low byte loads the upper seven bits from the latch.
// - Pointer 0x1F means empty; pop from entry zero returns there.
`default_nettype none

module plrs_top
  import plrs_pkg::*;
#(
  parameter int          BRA_OFS_W   = 9,
  parameter logic [14:0] VECTOR_ADDR = 15'h0004
)
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [plrs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [plrs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      cmd_valid,
  input  wire plrs_pkg::plrs_op_t        cmd_op,
  input  wire logic [plrs_pkg::CALL_OPD_W-1:0] cmd_operand,
  input  wire logic [plrs_pkg::BYTE_W-1:0] accumulator,
  output logic [plrs_pkg::PC_W-1:0]      pc,
  output logic                           irq,
  output logic                           stack_fault_reset
);

  import plrs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PC_W-1:0]   pc_reg;
  logic [PCH_W-1:0]  pc_high_latch_reg;
  logic [PTR_W-1:0]  return_stack_pointer_reg;
  logic              fault_rst_en_reg;
  logic [ST_W-1:0]   status_reg;
  logic [ST_W-1:0]   mask_reg;
  logic              irq_reg;
  logic              fault_reg;
  logic              awready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_fire   = awready_reg;
  wire rd_fire   = arready_reg;
  wire wr_lane   = s_axi_wstrb[0];
  wire [BYTE_W-1:0] wr_byte = s_axi_wdata[BYTE_W-1:0];
  wire hit_pcl   = s_axi_awaddr == REG_PC_LOW;
  wire hit_lat   = s_axi_awaddr == REG_PC_LATCH;
  wire hit_ptr   = s_axi_awaddr == REG_STACK_PTR;
  wire hit_tl    = s_axi_awaddr == REG_TOP_LOW;
  wire hit_th    = s_axi_awaddr == REG_TOP_HIGH;
  wire hit_ctl   = s_axi_awaddr == REG_CTRL;
  wire hit_st    = s_axi_awaddr == REG_IRQ_STATUS;
  wire hit_msk   = s_axi_awaddr == REG_IRQ_MASK;
  wire wr_mapped = hit_pcl | hit_lat | hit_ptr | hit_tl | hit_th | hit_ctl | hit_st | hit_msk;
  wire wr_en_b   = wr_fire & wr_lane;
  wire sw_pcl    = wr_en_b & hit_pcl;
  wire sw_ptr    = wr_en_b & hit_ptr;
  wire sw_tl     = wr_en_b & hit_tl;
  wire sw_th     = wr_en_b & hit_th;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  wire op_call  = cmd_valid & (cmd_op == PLRS_OP_CALL);
  wire op_call_via_accumulator = cmd_valid & (cmd_op == PLRS_OP_CALL_VIA_ACCUMULATOR);
  wire op_brw   = cmd_valid & (cmd_op == PLRS_OP_BRW);
  wire op_bra   = cmd_valid & (cmd_op == PLRS_OP_BRA);
  wire op_intr  = cmd_valid & (cmd_op == PLRS_OP_INTR);
  wire op_step  = cmd_valid & (cmd_op == PLRS_OP_STEP);
  wire op_ret   = cmd_valid & ((cmd_op == PLRS_OP_RETURN) | (cmd_op == PLRS_OP_RETLIT)
                  | (cmd_op == PLRS_OP_RETINT));
  wire do_push  = op_call | op_call_via_accumulator | op_intr;
  wire do_pop   = op_ret;

  // ----------------------------------------------------------------
  // Stack pointer and events
  // ----------------------------------------------------------------
  wire [PTR_W-1:0] ptr_inc = return_stack_pointer_reg + PTR_STEP;
  wire [PTR_W-1:0] ptr_dec = return_stack_pointer_reg - PTR_STEP;
  wire ptr_empty = return_stack_pointer_reg == PTR_EMPTY;
  wire ovf_evt   = do_push & ~ptr_empty & (return_stack_pointer_reg >= PTR_LAST);
  wire unf_evt   = do_pop & ptr_empty;
  wire [ST_W-1:0] evt = {unf_evt, ovf_evt};
  wire [PTR_W-1:0] ptr_next = do_push ? ptr_inc :
                              do_pop  ? ptr_dec :
                              sw_ptr  ? wr_byte[PTR_W-1:0] :
                              return_stack_pointer_reg;

  // ----------------------------------------------------------------
  // Stack storage access
  // ----------------------------------------------------------------
  wire [PC_W-1:0]  pc_inc   = pc_reg + PC_STEP;
  wire [PC_W-1:0]  top_entry;
  wire [IDX_W-1:0] top_idx  = return_stack_pointer_reg[IDX_W-1:0];
  wire [PC_W-1:0]  push_val = op_intr ? pc_reg : pc_inc;
  wire [PC_W-1:0]  sw_top   = sw_tl ? {top_entry[PC_W-1:BYTE_W], wr_byte}
                                    : {wr_byte[PCH_W-1:0], top_entry[BYTE_W-1:0]};
  wire             mem_we   = do_push | (~cmd_valid & (sw_tl | sw_th));
  wire [IDX_W-1:0] mem_wa   = do_push ? ptr_inc[IDX_W-1:0] : top_idx;
  wire [PC_W-1:0]  mem_wd   = do_push ? push_val : sw_top;

  plrs_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W),
    .AW    (IDX_W)
  ) u_stack (
    .aclk    (aclk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (top_idx),
    .rd_data (top_entry)
  );

  // ----------------------------------------------------------------
  // Program counter selection
  // ----------------------------------------------------------------
  wire [PC_W-1:0] call_tgt  = {pc_high_latch_reg[PCH_W-1:LATCH_SEG_LO], cmd_operand};
  wire [PC_W-1:0] call_via_accumulator_tgt = {pc_high_latch_reg, accumulator};
  wire [PC_W-1:0] brw_tgt   = pc_inc + {{(PC_W-BYTE_W){1'b0}}, accumulator};
  wire [PC_W-1:0] bra_ofs   = {{(PC_W-BRA_OFS_W){cmd_operand[BRA_OFS_W-1]}},
                               cmd_operand[BRA_OFS_W-1:0]};
  wire [PC_W-1:0] bra_tgt   = pc_inc + bra_ofs;
  wire [PC_W-1:0] pcl_tgt   = {pc_high_latch_reg, wr_byte};
  wire [PC_W-1:0] pc_next   = op_call  ? call_tgt  :
                              op_call_via_accumulator ? call_via_accumulator_tgt :
                              op_brw   ? brw_tgt   :
                              op_bra   ? bra_tgt   :
                              op_ret   ? top_entry :
                              op_intr  ? VECTOR_ADDR :
                              op_step  ? pc_inc    :
                              sw_pcl   ? pcl_tgt   :
                              pc_reg;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  wire [ST_W-1:0] st_clr  = (wr_en_b & hit_st) ? wr_byte[ST_W-1:0] : {ST_W{1'b0}};
  wire [ST_W-1:0] st_next = (status_reg & ~st_clr) | evt;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire [31:0] rd_pcl = {{(32-BYTE_W){1'b0}}, pc_reg[BYTE_W-1:0]};
  wire [31:0] rd_lat = {{(32-PCH_W){1'b0}}, pc_high_latch_reg};
  wire [31:0] rd_ptr = {{(32-PTR_W){1'b0}}, return_stack_pointer_reg};
  wire [31:0] rd_tl  = {{(32-BYTE_W){1'b0}}, top_entry[BYTE_W-1:0]};
  wire [31:0] rd_th  = {{(32-PCH_W){1'b0}}, top_entry[PC_W-1:BYTE_W]};
  wire [31:0] rd_ctl = {31'h00000000, fault_rst_en_reg};
  wire [31:0] rd_st  = {{(32-ST_W){1'b0}}, status_reg};
  wire [31:0] rd_msk = {{(32-ST_W){1'b0}}, mask_reg};
  wire [7:0]  ra     = s_axi_araddr;
  wire        rd_ok  = (ra == REG_PC_LOW) | (ra == REG_PC_LATCH) | (ra == REG_STACK_PTR)
                       | (ra == REG_TOP_LOW) | (ra == REG_TOP_HIGH) | (ra == REG_CTRL)
                       | (ra == REG_IRQ_STATUS) | (ra == REG_IRQ_MASK);
  wire [31:0] rd_val = (ra == REG_PC_LOW)     ? rd_pcl :
                       (ra == REG_PC_LATCH)   ? rd_lat :
                       (ra == REG_STACK_PTR)  ? rd_ptr :
                       (ra == REG_TOP_LOW)    ? rd_tl  :
                       (ra == REG_TOP_HIGH)   ? rd_th  :
                       (ra == REG_CTRL)       ? rd_ctl :
                       (ra == REG_IRQ_STATUS) ? rd_st  :
                       (ra == REG_IRQ_MASK)   ? rd_msk :
                       32'h00000000;

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_reg                   <= PC_RESET;
      pc_high_latch_reg        <= '0;
      return_stack_pointer_reg <= PTR_EMPTY;
      fault_rst_en_reg         <= 1'b0;
      status_reg               <= '0;
      mask_reg                 <= '0;
      irq_reg                  <= 1'b0;
      fault_reg                <= 1'b0;
    end
    else
    begin
      pc_reg                   <= pc_next;
      return_stack_pointer_reg <= ptr_next;
      status_reg               <= st_next;
      irq_reg                  <= |(st_next & mask_reg);
      fault_reg                <= fault_rst_en_reg & (|evt);
      if (wr_en_b & hit_lat)
        pc_high_latch_reg <= wr_byte[PCH_W-1:0];
      if (wr_en_b & hit_ctl)
        fault_rst_en_reg <= wr_byte[CTRL_FAULT_RST];
      if (wr_en_b & hit_msk)
        mask_reg <= wr_byte[ST_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end
    else
    begin
      awready_reg <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
      arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_val;
        rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready     = awready_reg;
  assign s_axi_wready      = awready_reg;
  assign s_axi_bvalid      = bvalid_reg;
  assign s_axi_bresp       = bresp_reg;
  assign s_axi_arready     = arready_reg;
  assign s_axi_rvalid      = rvalid_reg;
  assign s_axi_rresp       = rresp_reg;
  assign s_axi_rdata       = rdata_reg;
  assign pc                = pc_reg;
  assign irq               = irq_reg;
  assign stack_fault_reset = fault_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence push_seen;
    do_push;
  endsequence

  sequence pop_seen;
    do_pop;
  endsequence

  reset_pc_a: assert property ($rose(aresetn) |-> pc_reg == PC_RESET && ptr_empty)
    else $error("pc or pointer not cleared by reset");
  call_load_a: assert property (op_call |=> pc_reg == $past(call_tgt))
    else $error("call target wrong");
  call_via_accumulator_load_a: assert property (op_call_via_accumulator |=> pc_reg[BYTE_W-1:0] == $past(accumulator)
    && pc_reg[PC_W-1:BYTE_W] == $past(pc_high_latch_reg))
    else $error("computed call target wrong");
  brw_target_a: assert property (op_brw |=> pc_reg == PC_W'($past(pc_reg) + PC_STEP
    + PC_W'($past(accumulator))))
    else $error("accumulator jump target wrong");
  bra_target_a: assert property (op_bra |=> pc_reg == $past(bra_tgt))
    else $error("literal jump target wrong");
  push_order_a: assert property (push_seen |=> return_stack_pointer_reg
    == PTR_W'($past(return_stack_pointer_reg) + PTR_STEP)
    && top_entry == $past(push_val))
    else $error("push did not advance and store");
  pop_order_a: assert property (pop_seen |=> pc_reg == $past(top_entry)
    && return_stack_pointer_reg == PTR_W'($past(return_stack_pointer_reg) - PTR_STEP))
    else $error("pop did not load and retreat");
  latch_keep_a: assert property ((do_push || do_pop) && !(wr_en_b && hit_lat)
    |=> $stable(pc_high_latch_reg))
    else $error("latch changed by stack operation");
  ovf_flag_a: assert property (ovf_evt |=> status_reg[ST_OVF])
    else $error("overflow flag not set");
  unf_flag_a: assert property (unf_evt |=> status_reg[ST_UNF] ##1 (status_reg[ST_UNF]
    || $past(st_clr[ST_UNF])))
    else $error("underflow flag not set");
  pcl_write_a: assert property (sw_pcl && !cmd_valid |=> pc_reg == $past(pcl_tgt))
    else $error("low byte write did not pull latch");

endmodule

`default_nettype wire

// ==== verification/plrs_decoder_model.sv ====
// Decoder stand-in: issues one core command per call of issue.
// Assumes the block samples commands on the shared rising edge.
`default_nettype none

module plrs_decoder_model
  import plrs_pkg::*;
(
  input  wire logic                 aclk,
  output logic                      cmd_valid,
  output var plrs_pkg::plrs_op_t    cmd_op,
  output logic [10:0]               cmd_operand,
  output logic [7:0]                accumulator
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = PLRS_OP_STEP;
    cmd_operand = 11'h000;
    accumulator = 8'h00;
  end

  // ------------------------------------------------------------
  // One command, then idle with inverted operands
  // ------------------------------------------------------------
  task automatic issue(input plrs_op_t op, input logic [10:0] o, input logic [7:0] a);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_operand <= o;
    accumulator <= a;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_operand <= ~o;
    accumulator <= ~a;
  endtask
endmodule

`default_nettype wire

// ==== verification/pc_load_and_return_stack_tb.sv ====
// Bench for the counter and return stack block, with a reference model.
// Assumes the decoder stand-in and AXI4-Lite access to the registers.
`default_nettype none

module pc_load_and_return_stack_tb
  import plrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [14:0] VEC = 15'h0004;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, cmd_valid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  plrs_op_t    cmd_op;
  logic [10:0] cmd_operand;
  logic [7:0]  acc;
  logic [14:0] pc;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  seed = 8'h59;
  logic [14:0] m_pc, m_stk [16];
  logic [4:0]  m_ptr;
  logic [6:0]  m_latch;
  logic [1:0]  m_st, m_mask;
  logic        sfr, m_ev, m_en;

  always #12.5 aclk = ~aclk;

  plrs_top plrs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_operand(cmd_operand), .accumulator(acc), .pc(pc), .irq(irq),
    .stack_fault_reset(sfr));

  plrs_decoder_model plrs_decoder_model_inst (.aclk(aclk), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_operand(cmd_operand), .accumulator(acc));

  // ------------------------------------------------------------
  // Checking, reporting and timeout
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t expected %h got %h", $time, e, g);
    end
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  // ------------------------------------------------------------
  // AXI4-Lite master
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(e, rdata);
    chk(32'(er), 32'(rresp));
  endtask

  // ------------------------------------------------------------
  // Reference model of counter and stack
  // ------------------------------------------------------------
  task automatic push(input logic [14:0] v, input logic [14:0] t);
    m_ev = m_ptr >= 5'h0f && m_ptr <= 5'h1e;
    if (m_ev) m_st[0] = 1'b1;
    m_ptr = m_ptr + PTR_STEP;
    m_stk[m_ptr[3:0]] = v;
    m_pc = t;
  endtask

  task automatic run(input plrs_op_t op, input logic [10:0] o, input logic [7:0] a);
    m_ev = 1'b0;
    case (op)
      PLRS_OP_STEP: m_pc = m_pc + PC_STEP;
      PLRS_OP_CALL: push(m_pc + PC_STEP, {m_latch[6:3], o});
      PLRS_OP_CALL_VIA_ACCUMULATOR: push(m_pc + PC_STEP, {m_latch, a});
      PLRS_OP_BRW: m_pc = m_pc + PC_STEP + 15'(a);
      PLRS_OP_BRA: m_pc = m_pc + PC_STEP + 15'($signed(o[8:0]));
      PLRS_OP_INTR: push(m_pc, VEC);
      default:
      begin
        m_ev = m_ptr == PTR_EMPTY;
        if (m_ev) m_st[1] = 1'b1;
        m_pc = m_stk[m_ptr[3:0]];
        m_ptr = m_ptr - PTR_STEP;
      end
    endcase
    plrs_decoder_model_inst.issue(op, o, a);
    #1;
    chk(32'(m_pc), 32'(pc));
    chk(32'(m_ev & m_en), 32'(sfr));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    m_pc = PC_RESET;
    m_ptr = PTR_EMPTY;
    m_latch = 7'h55;
    m_st = 2'h0;
    m_mask = 2'h1;
    m_en = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(32'h0, 32'(pc));
    rd(REG_STACK_PTR, 32'h1f, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(REG_PC_LATCH, 32'h55, RESP_OKAY);
    $display("test reset done");
    run(PLRS_OP_CALL, 11'h5a3, 8'h00);
    run(PLRS_OP_CALL_VIA_ACCUMULATOR, 11'h000, 8'hf0);
    run(PLRS_OP_BRW, 11'h000, 8'hff);
    run(PLRS_OP_BRA, 11'h100, 8'h00);
    run(PLRS_OP_BRA, 11'h0ff, 8'h00);
    run(PLRS_OP_STEP, 11'h000, 8'h00);
    run(PLRS_OP_RETLIT, 11'h000, 8'h00);
    run(PLRS_OP_RETURN, 11'h000, 8'h00);
    run(PLRS_OP_INTR, 11'h000, 8'h00);
    run(PLRS_OP_RETINT, 11'h000, 8'h00);
    rd(REG_PC_LATCH, 32'h55, RESP_OKAY);
    $display("test jumps done");
    for (int i = 0; i < 17; i++) run(PLRS_OP_CALL, 11'(i * 37), 8'h00);
    rd(REG_STACK_PTR, 32'(m_ptr), RESP_OKAY);
    rd(REG_IRQ_STATUS, 32'(m_st), RESP_OKAY);
    chk(32'(|(m_st & m_mask)), 32'(irq));
    for (int i = 0; i < 16; i++) run(PLRS_OP_RETURN, 11'h000, 8'h00);
    wr(REG_IRQ_STATUS, 32'h3, RESP_OKAY);
    m_st = 2'h0;
    run(PLRS_OP_RETURN, 11'h000, 8'h00);
    run(PLRS_OP_RETURN, 11'h000, 8'h00);
    rd(REG_IRQ_STATUS, 32'(m_st), RESP_OKAY);
    chk(32'(|(m_st & m_mask)), 32'(irq));
    wr(REG_IRQ_MASK, 32'h3, RESP_OKAY);
    m_mask = 2'h3;
    repeat (2) @(posedge aclk);
    chk(32'(|(m_st & m_mask)), 32'(irq));
    wr(REG_IRQ_STATUS, 32'h3, RESP_OKAY);
    m_st = 2'h0;
    repeat (2) @(posedge aclk);
    chk(32'h0, 32'(irq));
    $display("test wrap done");
    wr(REG_STACK_PTR, 32'h3, RESP_OKAY);
    m_ptr = 5'h03;
    wr(REG_TOP_LOW, 32'h12, RESP_OKAY);
    wr(REG_TOP_HIGH, 32'h34, RESP_OKAY);
    m_stk[3] = 15'h3412;
    rd(REG_TOP_LOW, 32'h12, RESP_OKAY);
    rd(REG_TOP_HIGH, 32'h34, RESP_OKAY);
    run(PLRS_OP_RETURN, 11'h000, 8'h00);
    rd(REG_STACK_PTR, 32'(m_ptr), RESP_OKAY);
    wr(REG_PC_LOW, 32'hab, RESP_OKAY);
    m_pc = {m_latch, 8'hab};
    #1;
    chk(32'(m_pc), 32'(pc));
    wr(8'h24, 32'h1, RESP_SLVERR);
    rd(8'h24, 32'h0, RESP_SLVERR);
    $display("test software done");
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    m_en = 1'b1;
    repeat (80) run(plrs_op_t'(rnd() % 8'h09), 11'({rnd(), rnd()}), rnd());
    $display("test random done");
    end_sim();
  end
endmodule

`default_nettype wire
